// ===== eewc_pkg.sv
package eewc_pkg;

    // Line layout: sixteen pin channels, then the supply detector, two comparators, clock and timer wakes.
    localparam int NUM_LINES   = 21;
    localparam int NUM_PINS    = 18;
    localparam int NUM_PIN_CH  = 16;
    localparam int LINE_SUPPLY = 16;
    localparam int LINE_COMP0  = 17;
    localparam int LINE_COMP1  = 18;
    localparam int LINE_RTC    = 19;
    localparam int LINE_LOW_POWER_TIMER  = 20;

    // Pin select fields: one byte lane per channel, four channels to a word.
    localparam int SEL_W       = 5;
    localparam int SEL_FIELD_W = 8;
    localparam int SEL_PER_REG = 4;
    localparam int NUM_SEL_REG = 4;

    // Register offsets within the block.
    localparam int ADDR_W = 12;
    localparam logic [ADDR_W-1:0] OFS_INT_MASK = 12'h000;
    localparam logic [ADDR_W-1:0] OFS_EVT_MASK = 12'h004;
    localparam logic [ADDR_W-1:0] OFS_RISE     = 12'h008;
    localparam logic [ADDR_W-1:0] OFS_FALL     = 12'h00c;
    localparam logic [ADDR_W-1:0] OFS_PEND     = 12'h010;
    localparam logic [ADDR_W-1:0] OFS_SEL0     = 12'h014;
    localparam logic [ADDR_W-1:0] SEL_STRIDE   = 12'h004;

    // Reset values and writable bits.
    localparam logic [NUM_LINES-1:0] RST_MASK      = 21'h000000;
    localparam logic [NUM_LINES-1:0] RST_EDGE      = 21'h000000;
    localparam logic [NUM_LINES-1:0] EDGE_CFG_BITS = 21'h07ffff;
    localparam logic [SEL_W-1:0]     RST_SEL       = 5'h00;

    // Published bus encodings.
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic       HRESP_OKAY    = 1'h0;

    // Internal sources other than pins.
    typedef struct packed {
        logic       supply;
        logic [1:0] comp;
        logic       rtc;
        logic       low_power_timer;
    } eewc_src_t;

    // Latched address phase of a bus transfer.
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic              write;
        logic              valid;
    } eewc_aphase_t;

endpackage

// ===== eewc_edge_catch.sv
`timescale 1ns/1ps
module eewc_edge_catch (
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic src,
    input  wire logic rise_en,
    input  wire logic fall_en,
    output logic      event_pulse,
    output logic      wake_raw
);
    import eewc_pkg::*;

    logic       tog_rise;
    logic       tog_fall;
    logic       next_tog_rise;
    logic       next_tog_fall;
    logic [1:0] sync1;
    logic [1:0] sync2;
    logic [1:0] seen;

    // Toggles flip on the source edge itself, so a pulse shorter than hclk still leaves a mark.
    assign next_tog_rise = rise_en ? ~tog_rise : tog_rise; // [R5]
    assign next_tog_fall = fall_en ? ~tog_fall : tog_fall; // [R2]

    // Rising-edge capture clocked by the source, so it works with hclk stopped.
    always_ff @(posedge src or negedge hresetn) begin
        if (!hresetn) begin
            tog_rise <= 1'b0;
        end else begin
            tog_rise <= next_tog_rise; // [R5]
        end
    end

    // Falling-edge capture clocked by the inverted source.
    always_ff @(negedge src or negedge hresetn) begin
        if (!hresetn) begin
            tog_fall <= 1'b0;
        end else begin
            tog_fall <= next_tog_fall; // [R5]
        end
    end

    // Two-stage synchroniser into hclk, then a copy of what has already been reported.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync1 <= 2'h0;
            sync2 <= 2'h0;
            seen  <= 2'h0;
        end else begin
            sync1 <= {tog_fall, tog_rise};
            sync2 <= sync1;
            seen  <= sync2;
        end
    end

    // A change after the synchroniser is one hclk pulse; a rising and a falling edge caught before the same hclk sample merge into one event.
    assign event_pulse = |(sync2 ^ seen);
    // The raw difference needs no hclk, which lets it end stop mode.
    assign wake_raw    = |({tog_fall, tog_rise} ^ seen); // [R7]

endmodule

// ===== eewc_top.sv
// Chosen here: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ps
// Functional notes
// (R1) Lines: sixteen pin channels, supply detector, two comparators, clock wake, timer wake.
// (R2) Pin, supply and comparator lines trigger on rising, falling or both edges.
// (R3) Each pin channel 0..15 picks any pin through its select field.
// (R4) Every line has independent interrupt and event mask bits in registers.
// (R5) Edges are caught asynchronously, so pulses shorter than a clock are kept.
// (R6) Each detected event is latched in a pending register readable by software.
// (R7) Every source can produce a wake-up that ends stop mode.
// (R8) The supply detector drives line 16 with its own edge settings.
// (R9) Each comparator can interrupt and wake from sleep and stop.
// (R10) Pending flags hold until a software write clears them; request follows flag and mask.
module eewc_top (
    input  wire logic                       hclk,
    input  wire logic                       hresetn,
    input  wire logic                       hsel,
    input  wire logic [31:0]                haddr,
    input  wire logic [1:0]                 htrans,
    input  wire logic                       hwrite,
    input  wire logic [2:0]                 hsize,
    input  wire logic [31:0]                hwdata,
    input  wire logic                       hready,
    output logic                            hreadyout,
    output logic                            hresp,
    output logic [31:0]                     hrdata,
    input  wire logic [eewc_pkg::NUM_PINS-1:0]  pin_in,
    input  wire eewc_pkg::eewc_src_t        src,
    output logic [eewc_pkg::NUM_LINES-1:0]  irq_line,
    output logic                            evt_pulse,
    output logic                            wake_req
);
    import eewc_pkg::*;

    logic [NUM_LINES-1:0] int_mask;
    logic [NUM_LINES-1:0] evt_mask;
    logic [NUM_LINES-1:0] rise_sel;
    logic [NUM_LINES-1:0] fall_sel;
    logic [NUM_LINES-1:0] pend;
    logic [SEL_W-1:0]     sel      [NUM_PIN_CH];
    eewc_aphase_t         aph;
    logic [NUM_LINES-1:0] next_int_mask;
    logic [NUM_LINES-1:0] next_evt_mask;
    logic [NUM_LINES-1:0] next_rise_sel;
    logic [NUM_LINES-1:0] next_fall_sel;
    logic [NUM_LINES-1:0] next_pend;
    logic [SEL_W-1:0]     next_sel [NUM_PIN_CH];
    eewc_aphase_t         next_aph;
    logic [31:0]          next_hrdata;
    logic                 next_evt_pulse;
    logic [NUM_LINES-1:0] line_src;
    logic [NUM_LINES-1:0] line_rise_en;
    logic [NUM_LINES-1:0] line_fall_en;
    logic [NUM_LINES-1:0] line_event;
    logic [NUM_LINES-1:0] line_wake;
    logic                 wr_en;
    logic                 rd_start;

    // Address of the select register that holds a given channel.
    function automatic logic [ADDR_W-1:0] sel_addr(input int ch);
        sel_addr = OFS_SEL0 + SEL_STRIDE * ADDR_W'(ch / SEL_PER_REG);
    endfunction

    // Pin channels: any pin may feed any channel; an out-of-range select reads as a quiet low line.
    // The mux feeds an edge-clocked flop, so a select change can itself look like an edge.
    generate
        for (genvar ch = 0; ch < NUM_PIN_CH; ch++) begin : g_pin_mux
            assign line_src[ch] = (sel[ch] < SEL_W'(NUM_PINS)) ? pin_in[sel[ch]] : 1'b0; // [R3] [R1]
        end
    endgenerate

    // Internal sources on their fixed lines.
    assign line_src[LINE_SUPPLY] = src.supply; // [R8]
    assign line_src[LINE_COMP0]  = src.comp[0]; // [R9]
    assign line_src[LINE_COMP1]  = src.comp[1]; // [R9]
    assign line_src[LINE_RTC]    = src.rtc; // [R1]
    assign line_src[LINE_LOW_POWER_TIMER]  = src.low_power_timer; // [R1]

    // Clock and timer wakes are fixed to their rising edge; the others follow software settings.
    assign line_rise_en = (rise_sel & EDGE_CFG_BITS) | ~EDGE_CFG_BITS; // [R2] [R8]
    assign line_fall_en = fall_sel & EDGE_CFG_BITS; // [R2] [R8]

    // One edge catcher per line.
    generate
        for (genvar ln = 0; ln < NUM_LINES; ln++) begin : g_line
            eewc_edge_catch u_catch (
                .hclk        (hclk),
                .hresetn     (hresetn),
                .src         (line_src[ln]),
                .rise_en     (line_rise_en[ln]),
                .fall_en     (line_fall_en[ln]),
                .event_pulse (line_event[ln]),
                .wake_raw    (line_wake[ln])
            );
        end
    endgenerate

    // Zero-wait slave: the answer is always ready and always OKAY.
    assign hreadyout = 1'b1;
    assign hresp     = HRESP_OKAY;
    assign wr_en     = aph.valid & aph.write;
    assign rd_start  = hready & hsel & (htrans == HTRANS_NONSEQ) & ~hwrite;

    // Requests: an unmasked pending flag stays asserted; this also wakes from sleep.
    assign irq_line = pend & int_mask; // [R10] [R4] [R9]
    // Stop-mode wake comes straight from the edge catchers, so it needs no running clock.
    assign wake_req = |(line_wake & evt_mask) | |irq_line; // [R7] [R9]

    // Register file, pending flags and bus address phase.
    always_comb begin
        next_int_mask  = int_mask;
        next_evt_mask  = evt_mask;
        next_rise_sel  = rise_sel;
        next_fall_sel  = fall_sel;
        next_sel       = sel;
        next_aph       = aph;
        next_hrdata    = hrdata;
        next_evt_pulse = |(line_event & evt_mask); // [R7] [R4]
        next_pend      = pend;
        if (wr_en) begin
            unique case (aph.addr)
                OFS_INT_MASK: next_int_mask = hwdata[NUM_LINES-1:0]; // [R4]
                OFS_EVT_MASK: next_evt_mask = hwdata[NUM_LINES-1:0]; // [R4]
                OFS_RISE:     next_rise_sel = hwdata[NUM_LINES-1:0] & EDGE_CFG_BITS; // [R2]
                OFS_FALL:     next_fall_sel = hwdata[NUM_LINES-1:0] & EDGE_CFG_BITS; // [R2]
                OFS_PEND:     next_pend     = pend & ~hwdata[NUM_LINES-1:0]; // [R10]
                default:      next_pend     = pend;
            endcase
            for (int ch = 0; ch < NUM_PIN_CH; ch++) begin
                if (aph.addr == sel_addr(ch)) begin
                    next_sel[ch] = hwdata[SEL_FIELD_W*(ch % SEL_PER_REG) +: SEL_W]; // [R3]
                end
            end
        end
        // A new event wins over a clear in the same cycle.
        next_pend = next_pend | line_event; // [R6] [R10]
        // Address phase is sampled only when the bus is ready.
        if (hready) begin
            next_aph.addr  = haddr[ADDR_W-1:0];
            next_aph.write = hwrite;
            next_aph.valid = hsel & (htrans == HTRANS_NONSEQ);
        end
        // Read data is taken from next values, so a read right after a write sees the new contents.
        if (rd_start) begin
            next_hrdata = 32'h00000000;
            unique case (haddr[ADDR_W-1:0])
                OFS_INT_MASK: next_hrdata[NUM_LINES-1:0] = next_int_mask;
                OFS_EVT_MASK: next_hrdata[NUM_LINES-1:0] = next_evt_mask;
                OFS_RISE:     next_hrdata[NUM_LINES-1:0] = next_rise_sel;
                OFS_FALL:     next_hrdata[NUM_LINES-1:0] = next_fall_sel;
                OFS_PEND:     next_hrdata[NUM_LINES-1:0] = next_pend; // [R6]
                default:      next_hrdata = 32'h00000000;
            endcase
            for (int ch = 0; ch < NUM_PIN_CH; ch++) begin
                if (haddr[ADDR_W-1:0] == sel_addr(ch)) begin
                    next_hrdata[SEL_FIELD_W*(ch % SEL_PER_REG) +: SEL_W] = next_sel[ch];
                end
            end
        end
    end

    // State registers; everything clears on system reset.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            int_mask  <= RST_MASK;
            evt_mask  <= RST_MASK;
            rise_sel  <= RST_EDGE;
            fall_sel  <= RST_EDGE;
            pend      <= RST_MASK;
            aph       <= '0;
            hrdata    <= 32'h00000000;
            evt_pulse <= 1'b0;
            for (int ch = 0; ch < NUM_PIN_CH; ch++) begin
                sel[ch] <= RST_SEL;
            end
        end else begin
            int_mask  <= next_int_mask;
            evt_mask  <= next_evt_mask;
            rise_sel  <= next_rise_sel;
            fall_sel  <= next_fall_sel;
            pend      <= next_pend;
            aph       <= next_aph;
            hrdata    <= next_hrdata;
            evt_pulse <= next_evt_pulse;
            sel       <= next_sel;
        end
    end

endmodule

// ===== eewc_core_model.sv
`timescale 1ns/1ps
module eewc_core_model (
    input  wire logic                          hclk,
    input  wire logic                          hresetn,
    input  wire logic [eewc_pkg::NUM_LINES-1:0] irq_line,
    input  wire logic                          evt_pulse,
    input  wire logic                          wake_req,
    output logic [7:0]                         n_evt,
    output logic                               woke
);
    import eewc_pkg::*;
    logic [7:0] next_n_evt;
    logic       next_woke;
    // The core counts event pulses and remembers any wake; a level is enough since it may arrive with clocks off.
    always_comb begin
        next_n_evt = n_evt + {7'h00, evt_pulse};
        next_woke  = woke | wake_req | (|irq_line);
    end
    // State of the core side, cleared by system reset.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            n_evt <= 8'h00;
            woke  <= 1'b0;
        end else begin
            n_evt <= next_n_evt;
            woke  <= next_woke;
        end
    end
endmodule

// ===== eewc_top_sva.sv
`timescale 1ns/1ps
module eewc_top_chk (
    input wire logic                          hclk,
    input wire logic                          hresetn,
    input wire logic                          hsel,
    input wire logic [31:0]                   haddr,
    input wire logic [1:0]                    htrans,
    input wire logic                          hwrite,
    input wire logic                          hready,
    input wire logic [31:0]                   hwdata,
    input wire logic [31:0]                   hrdata,
    input wire logic [eewc_pkg::NUM_LINES-1:0] irq_line,
    input wire logic                          evt_pulse,
    input wire logic                          wake_req
);
    import eewc_pkg::*;
    logic        rd_ph;
    logic        wr_d;
    logic [11:0] wa;
    logic [20:0] mask_sh;
    logic [20:0] next_mask_sh;
    // Read address phases accepted by the slave.
    assign rd_ph = hsel && hready && htrans == HTRANS_NONSEQ && !hwrite;
    // Shadow of the interrupt mask, so gating is judged without looking inside.
    always_comb begin
        next_mask_sh = (wr_d && wa == OFS_INT_MASK) ? hwdata[20:0] : mask_sh;
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_d    <= 1'b0;
            wa      <= 12'h000;
            mask_sh <= 21'h000000;
        end else begin
            wr_d    <= hsel && hready && htrans == HTRANS_NONSEQ && hwrite;
            wa      <= haddr[11:0];
            mask_sh <= next_mask_sh;
        end
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_rd_at(logic [11:0] a);
        rd_ph && haddr[11:0] == a;
    endsequence
    property p_hold; !rd_ph |=> $stable(hrdata); endproperty
    property p_irq_fall; (|($past(irq_line) & ~irq_line)) |-> $past(wr_d); endproperty
    property p_irq_masked; (irq_line & ~mask_sh) == 21'h000000; endproperty
    property p_mask_rb; s_rd_at(OFS_INT_MASK) |=> hrdata == {11'h000, mask_sh}; endproperty
    property p_rise_fixed; s_rd_at(OFS_RISE) |=> hrdata[31:19] == 13'h0000; endproperty
    property p_unmapped; s_rd_at(12'h100) |=> hrdata == 32'h00000000; endproperty
    property p_wake_irq; (|irq_line) |-> wake_req; endproperty
    property p_evt_wake; evt_pulse |-> $past(wake_req); endproperty
    a_hold: assert property (p_hold) else $error("read data moved without a read");
    a_irq_fall: assert property (p_irq_fall) else $error("irq dropped without a write");
    a_irq_masked: assert property (p_irq_masked) else $error("irq on a masked line");
    a_mask_rb: assert property (p_mask_rb) else $error("mask readback differs");
    a_rise_fixed: assert property (p_rise_fixed) else $error("fixed lines have edge bits");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    a_wake_irq: assert property (p_wake_irq) else $error("irq without wake");
    a_evt_wake: assert property (p_evt_wake) else $error("event pulse without wake");
endmodule
bind eewc_top eewc_top_chk chk_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready, .hwdata, .hrdata,
    .irq_line, .evt_pulse, .wake_req);

// ===== tb.sv
`timescale 1ns/1ps
module tb;
    import eewc_pkg::*;
    // Flags, high bit first: rise, fall, final level, narrow pulse, expected event.
    typedef struct packed {
        logic [4:0] line;
        logic [4:0] pin;
        logic [4:0] flg;
    } eewc_row_t;
    logic                 hclk, hresetn, hsel, hwrite, hreadyout, hresp, evt_pulse, wake_req, woke;
    logic [1:0]           htrans;
    logic [2:0]           hsize;
    logic [31:0]          haddr, hwdata, hrdata, rd;
    logic [NUM_PINS-1:0]  pin_in;
    eewc_src_t            src;
    logic [NUM_LINES-1:0] irq_line;
    logic [7:0]           n_evt, e0;
    int                   n_errors = 0;
    int                   cmp_count = 0;
    eewc_row_t            rows [12] = '{{5'h00, 5'h00, 5'h15}, {5'h05, 5'h11, 5'h09}, {5'h0f, 5'h09, 5'h10},
        {5'h0f, 5'h09, 5'h19}, {5'h10, 5'h00, 5'h15}, {5'h10, 5'h00, 5'h0c}, {5'h11, 5'h00, 5'h09},
        {5'h12, 5'h00, 5'h1d}, {5'h13, 5'h00, 5'h15}, {5'h14, 5'h00, 5'h05}, {5'h14, 5'h00, 5'h08},
        {5'h03, 5'h04, 5'h17}};
    eewc_top dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
        .hreadyout, .hresp, .hrdata, .pin_in, .src, .irq_line, .evt_pulse, .wake_req);
    eewc_core_model core_u (.hclk, .hresetn, .irq_line, .evt_pulse, .wake_req, .n_evt, .woke);
    initial begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end
    // One single-word transfer; the wait on hready is left to the watchdog.
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        hsel   <= 1'b1;
        haddr  <= {20'h00000, a};
        hwrite <= w;
        htrans <= HTRANS_NONSEQ;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
        // Outputs launched at this edge settle before the caller looks at them.
        #1;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic set_src(input eewc_row_t r, input logic v);
        case (r.line)
            5'h10: src.supply <= v;
            5'h11: src.comp[0] <= v;
            5'h12: src.comp[1] <= v;
            5'h13: src.rtc <= v;
            5'h14: src.low_power_timer <= v;
            default: pin_in[r.pin] <= v;
        endcase
    endtask
    task results;
        $display("errors %0d comparisons %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // The whole run needs well under a thousand cycles.
    initial begin
        #1000000;
        n_errors++;
        results;
    end
    initial begin
        {hresetn, hsel, hwrite, htrans, haddr, hwdata, pin_in, src, rd} = '0;
        hsize = 3'h2;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        bus(1'b1, OFS_INT_MASK, 32'h001fffff);
        bus(1'b1, OFS_EVT_MASK, 32'h001fffff);
        foreach (rows[i]) begin
            set_src(rows[i], !rows[i].flg[2]);
            bus(1'b1, OFS_RISE, 32'(rows[i].flg[4]) << rows[i].line);
            bus(1'b1, OFS_FALL, 32'(rows[i].flg[3]) << rows[i].line);
            bus(1'b1, OFS_SEL0 + SEL_STRIDE * rows[i].line[3:2], 32'(rows[i].pin) << (8 * rows[i].line[1:0]));
            repeat (4) @(posedge hclk);
            bus(1'b1, OFS_PEND, 32'h001fffff);
            e0 = n_evt;
            set_src(rows[i], rows[i].flg[2]);
            if (rows[i].flg[1]) begin
                #20 set_src(rows[i], !rows[i].flg[2]);
            end
            repeat (5) @(posedge hclk);
            bus(1'b0, OFS_PEND, 32'h0);
            chk(rd, 32'(rows[i].flg[0]) << rows[i].line);
            chk({11'h000, irq_line}, 32'(rows[i].flg[0]) << rows[i].line);
            chk({24'h000000, n_evt - e0}, 32'(rows[i].flg[0]));
        end
        // Pending flag of line 3 must survive a zero write and masking.
        bus(1'b1, OFS_PEND, 32'h0);
        bus(1'b1, OFS_INT_MASK, 32'h0);
        bus(1'b0, OFS_PEND, 32'h0);
        chk(rd, 32'h8);
        chk({11'h000, irq_line}, 32'h0);
        bus(1'b1, OFS_INT_MASK, 32'h8);
        chk({11'h000, irq_line}, 32'h8);
        bus(1'b1, OFS_PEND, 32'h8);
        chk({11'h000, irq_line}, 32'h0);
        bus(1'b0, OFS_INT_MASK, 32'h0);
        chk(rd, 32'h8);
        bus(1'b0, 12'h100, 32'h0);
        chk(rd, 32'h0);
        chk({31'h0, woke}, 32'h1);
        // An event on a line without its event bit latches but sends no pulse.
        bus(1'b1, OFS_EVT_MASK, 32'h0);
        e0 = n_evt;
        set_src(rows[11], 1'b1);
        repeat (5) @(posedge hclk);
        bus(1'b0, OFS_PEND, 32'h0);
        chk(rd, 32'h8);
        chk({24'h000000, n_evt - e0}, 32'h0);
        // With requests masked, an event-enabled line must still raise wake before any clock edge.
        bus(1'b1, OFS_INT_MASK, 32'h0);
        bus(1'b1, OFS_EVT_MASK, 32'h8);
        set_src(rows[11], 1'b0);
        repeat (2) @(posedge hclk);
        e0 = n_evt;
        chk({31'h0, wake_req}, 32'h0);
        set_src(rows[11], 1'b1);
        #10 chk({31'h0, wake_req}, 32'h1);
        repeat (5) @(posedge hclk);
        chk({31'h0, wake_req}, 32'h0);
        chk({24'h000000, n_evt - e0}, 32'h1);
        // A second reset mid-run clears every register and request.
        hresetn <= 1'b0;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        for (int a = 0; a < 9; a++) begin
            bus(1'b0, 12'(4 * a), 32'h0);
            chk(rd, 32'h0);
        end
        chk({11'h000, irq_line}, 32'h0);
        chk({30'h0, hreadyout, hresp}, 32'h2);
        results;
    end
endmodule
